/* common/sar_pkg.sv */
// constants, state codes and register carrier for the alert response serial slave
// How it works
// (RQ1) acknowledge an alert response read only while the alert pin is held low in alert mode
// (RQ2) after that acknowledge, send own seven-bit address followed by a one
// (RQ3) while returning the address, a driven one read back as zero aborts the byte
// (RQ4) a returned address releases the alert pin; later alert reads ignored until new event
// (RQ5) control write: address, command 01h, one data byte, each acknowledged, then stop
// (RQ6) status read: command 00h, repeated start read, one byte, master refuses it, stop
// (RQ7) charge write starts at command 02h, high byte then low byte, each acknowledged
// (RQ8) charge read at 02h: repeated start read, high byte acknowledged, low byte refused
// (RQ9) a further written byte is acknowledged, pointer advances, byte lands in next register
// (RQ10) each read byte the master acknowledges advances the pointer and sends the next register
// (RQ11) charge above high or below low threshold sets its flag and pulls alert low if enabled
// (RQ12) with no pending alert, leave data released in the alert response acknowledge slot
package sar_pkg;

  localparam logic [6:0]  DEV_ADDR          = 7'h64;
  localparam logic [6:0]  ALERT_RESP_ADDR   = 7'h0C;
  localparam logic [7:0]  ALERT_REPLY       = {DEV_ADDR, 1'b1};

  localparam logic [7:0]  REG_EVENT_FLAGS   = 8'h00;
  localparam logic [7:0]  REG_SETUP_CONTROL = 8'h01;
  localparam logic [7:0]  REG_CHARGE_HIGH   = 8'h02;
  localparam logic [7:0]  REG_CHARGE_LOW    = 8'h03;

  localparam logic [7:0]  FLAGS_RESET       = 8'h00;
  localparam logic [7:0]  SETUP_RESET       = 8'h3C;
  localparam logic [15:0] CHARGE_RESET      = 16'h7FFF;

  localparam int          FLAG_HIGH_BIT     = 3;
  localparam int          FLAG_LOW_BIT      = 2;
  localparam int          MODE_MSB          = 2;
  localparam int          MODE_LSB          = 1;
  localparam logic [1:0]  MODE_ALERT        = 2'h2;

  localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_RX_ADDR = 8'h02,
    ST_RX_CMD  = 8'h04,
    ST_RX_DATA = 8'h08,
    ST_ACK_DRV = 8'h10,
    ST_TX_BYTE = 8'h20,
    ST_TX_ACK  = 8'h40,
    ST_IGNORE  = 8'h80
  } sar_state_e;

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  ctrl;
    logic [15:0] charge;
  } sar_regs_s;

endpackage

/* src/sar_slave.sv */
// serial slave with register access, thresholds and alert response handling
`timescale 1ns/10ps
module sar_slave (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin_i,
  output logic             sda_pin_o,
  output logic             sda_pin_oe,
  output logic             alert_or_charge_done_pin_o,
  output logic             alert_or_charge_done_pin_oe,
  input  wire logic        charge_step_up,
  input  wire logic        charge_step_down,
  input  wire logic [15:0] high_threshold,
  input  wire logic [15:0] low_threshold,
  output logic [15:0]      charge_count_value,
  output logic [7:0]       setup_value
);

  sar_pkg::sar_state_e state_r, state_nxt;
  sar_pkg::sar_state_e after_r, after_nxt;
  sar_pkg::sar_regs_s  regs_r, regs_nxt;
  logic [1:0]  scl_sync_r, sda_sync_r;
  logic        scl_d_r, sda_d_r;
  logic [7:0]  rx_sr_r, rx_sr_nxt;
  logic [7:0]  tx_sr_r, tx_sr_nxt;
  logic [7:0]  ptr_r, ptr_nxt;
  logic [3:0]  bitcnt_r, bitcnt_nxt;
  logic        is_ara_r, is_ara_nxt;
  logic        mack_r, mack_nxt;
  logic        pending_r, pending_nxt;
  logic        hi_prev_r, lo_prev_r;
  logic        scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
  logic        alert_mode, hi_cond, lo_cond, hi_evt, lo_evt;
  logic        wr_en, flags_clr, ara_done;
  logic [7:0]  wr_addr, wr_data;

  // read side of the register map; unmapped pointers read zero
  function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                          input sar_pkg::sar_regs_s r);
    logic [7:0] v;
    v = 8'h00;
    if (addr == sar_pkg::REG_EVENT_FLAGS) begin
      v = r.flags;
    end else if (addr == sar_pkg::REG_SETUP_CONTROL) begin
      v = r.ctrl;
    end else if (addr == sar_pkg::REG_CHARGE_HIGH) begin
      v = r.charge[15:8];
    end else if (addr == sar_pkg::REG_CHARGE_LOW) begin
      v = r.charge[7:0];
    end
    return v;
  endfunction

  // only the second sync stage and its delayed copy feed the edge logic
  assign scl_s    = scl_sync_r[1];
  assign sda_s    = sda_sync_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_c  = scl_s & scl_d_r & ~sda_s & sda_d_r;
  assign stop_c   = scl_s & scl_d_r & sda_s & ~sda_d_r;

  assign alert_mode = (regs_r.ctrl[sar_pkg::MODE_MSB:sar_pkg::MODE_LSB] == sar_pkg::MODE_ALERT);
  assign hi_cond    = (regs_r.charge > high_threshold);
  assign lo_cond    = (regs_r.charge < low_threshold);
  assign hi_evt     = hi_cond & ~hi_prev_r;
  assign lo_evt     = lo_cond & ~lo_prev_r;

  // open drain: only ever pull low
  assign sda_pin_o  = 1'b0;
  assign sda_pin_oe = (state_r == sar_pkg::ST_ACK_DRV) |
                      ((state_r == sar_pkg::ST_TX_BYTE) & ~tx_sr_r[7]);
  assign alert_or_charge_done_pin_o  = 1'b0;
  assign alert_or_charge_done_pin_oe = pending_r & alert_mode; // RQ11
  assign charge_count_value = regs_r.charge;
  assign setup_value        = regs_r.ctrl;

  always_comb begin
    state_nxt  = state_r;
    after_nxt  = after_r;
    rx_sr_nxt  = rx_sr_r;
    tx_sr_nxt  = tx_sr_r;
    ptr_nxt    = ptr_r;
    bitcnt_nxt = bitcnt_r;
    is_ara_nxt = is_ara_r;
    mack_nxt   = mack_r;
    wr_en      = 1'b0;
    wr_addr    = ptr_r;
    wr_data    = rx_sr_r;
    flags_clr  = 1'b0;
    ara_done   = 1'b0;
    // a repeated start restarts address reception from any state
    if (start_c) begin
      state_nxt  = sar_pkg::ST_RX_ADDR;
      bitcnt_nxt = 4'h0;
      is_ara_nxt = 1'b0;
    end else if (stop_c) begin
      state_nxt = sar_pkg::ST_IDLE;
    end else begin
      case (state_r)
        sar_pkg::ST_RX_ADDR, sar_pkg::ST_RX_CMD, sar_pkg::ST_RX_DATA: begin
          if (scl_rise) begin
            rx_sr_nxt  = {rx_sr_r[6:0], sda_s};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == sar_pkg::BITS_PER_BYTE) begin
            state_nxt = sar_pkg::ST_ACK_DRV;
            if (state_r == sar_pkg::ST_RX_ADDR) begin
              if (rx_sr_r[7:1] == sar_pkg::DEV_ADDR && !rx_sr_r[0]) begin
                after_nxt = sar_pkg::ST_RX_CMD; // RQ5
              end else if (rx_sr_r[7:1] == sar_pkg::DEV_ADDR) begin
                after_nxt = sar_pkg::ST_TX_BYTE; // RQ6
              end else if (rx_sr_r[7:1] == sar_pkg::ALERT_RESP_ADDR && rx_sr_r[0] &&
                           pending_r && alert_mode) begin
                after_nxt  = sar_pkg::ST_TX_BYTE; // RQ1
                is_ara_nxt = 1'b1;
              end else begin
                state_nxt = sar_pkg::ST_IGNORE; // RQ12
              end
            end else if (state_r == sar_pkg::ST_RX_CMD) begin
              ptr_nxt   = rx_sr_r; // RQ7
              after_nxt = sar_pkg::ST_RX_DATA;
            end else begin
              wr_en     = 1'b1; // RQ9
              ptr_nxt   = ptr_r + 8'h01;
              after_nxt = sar_pkg::ST_RX_DATA;
            end
          end
        end
        sar_pkg::ST_ACK_DRV: begin
          if (scl_fall) begin
            state_nxt  = after_r;
            bitcnt_nxt = 4'h0;
            if (after_r == sar_pkg::ST_TX_BYTE) begin
              tx_sr_nxt = is_ara_r ? sar_pkg::ALERT_REPLY : reg_read(ptr_r, regs_r); // RQ2
              flags_clr = ~is_ara_r && (ptr_r == sar_pkg::REG_EVENT_FLAGS);
            end
          end
        end
        sar_pkg::ST_TX_BYTE: begin
          if (scl_rise) begin
            bitcnt_nxt = bitcnt_r + 4'h1;
            // lost arbitration: release at once and wait for the next cycle
            if (is_ara_r && tx_sr_r[7] && !sda_s) begin
              state_nxt = sar_pkg::ST_IGNORE; // RQ3
            end
          end else if (scl_fall && bitcnt_r == sar_pkg::BITS_PER_BYTE) begin
            state_nxt = sar_pkg::ST_TX_ACK;
            tx_sr_nxt = 8'hFF;
            ara_done  = is_ara_r; // RQ4
          end else if (scl_fall) begin
            tx_sr_nxt = {tx_sr_r[6:0], 1'b1};
          end
        end
        sar_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_s;
          end else if (scl_fall && mack_r && !is_ara_r) begin
            state_nxt  = sar_pkg::ST_TX_BYTE; // RQ10
            bitcnt_nxt = 4'h0;
            ptr_nxt    = ptr_r + 8'h01;
            tx_sr_nxt  = reg_read(ptr_r + 8'h01, regs_r); // RQ8
            flags_clr  = ((ptr_r + 8'h01) == sar_pkg::REG_EVENT_FLAGS);
          end else if (scl_fall) begin
            state_nxt = sar_pkg::ST_IGNORE;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // register file, thresholds and alert pending state
  always_comb begin
    regs_nxt = regs_r;
    if (wr_en && wr_addr == sar_pkg::REG_SETUP_CONTROL) begin
      regs_nxt.ctrl = wr_data;
    end else if (wr_en && wr_addr == sar_pkg::REG_CHARGE_HIGH) begin
      regs_nxt.charge[15:8] = wr_data;
    end else if (wr_en && wr_addr == sar_pkg::REG_CHARGE_LOW) begin
      regs_nxt.charge[7:0] = wr_data;
    end else if (charge_step_up && !charge_step_down) begin
      regs_nxt.charge = regs_r.charge + 16'h0001;
    end else if (charge_step_down && !charge_step_up) begin
      regs_nxt.charge = regs_r.charge - 16'h0001;
    end
    // reading the flags clears them, but a flag set in the same cycle survives
    if (flags_clr) begin
      regs_nxt.flags = sar_pkg::FLAGS_RESET;
    end
    if (hi_cond) begin
      regs_nxt.flags[sar_pkg::FLAG_HIGH_BIT] = 1'b1; // RQ11
    end
    if (lo_cond) begin
      regs_nxt.flags[sar_pkg::FLAG_LOW_BIT] = 1'b1; // RQ11
    end
    pending_nxt = pending_r;
    if ((hi_evt || lo_evt) && alert_mode) begin
      pending_nxt = 1'b1; // RQ11
    end else if (ara_done) begin
      pending_nxt = 1'b0; // RQ4
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      state_r    <= sar_pkg::ST_IDLE;
      after_r    <= sar_pkg::ST_IDLE;
      rx_sr_r    <= 8'h00;
      tx_sr_r    <= 8'hFF;
      ptr_r      <= 8'h00;
      bitcnt_r   <= 4'h0;
      is_ara_r   <= 1'b0;
      mack_r     <= 1'b0;
      pending_r  <= 1'b0;
      hi_prev_r  <= 1'b0;
      lo_prev_r  <= 1'b0;
      regs_r     <= '{flags: sar_pkg::FLAGS_RESET, ctrl: sar_pkg::SETUP_RESET,
                      charge: sar_pkg::CHARGE_RESET};
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_pin};
      sda_sync_r <= {sda_sync_r[0], sda_pin_i};
      scl_d_r    <= scl_s;
      sda_d_r    <= sda_s;
      state_r    <= state_nxt;
      after_r    <= after_nxt;
      rx_sr_r    <= rx_sr_nxt;
      tx_sr_r    <= tx_sr_nxt;
      ptr_r      <= ptr_nxt;
      bitcnt_r   <= bitcnt_nxt;
      is_ara_r   <= is_ara_nxt;
      mack_r     <= mack_nxt;
      pending_r  <= pending_nxt;
      hi_prev_r  <= hi_cond;
      lo_prev_r  <= lo_cond;
      regs_r     <= regs_nxt;
    end
  end

  a_ara_ack_only_pending: assert property (@(posedge clk) disable iff (!reset_n) // RQ1
    (state_r == sar_pkg::ST_ACK_DRV && is_ara_r) |-> pending_r)
    else $error("alert response acknowledged with no pending alert");

  a_ara_reply_byte: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
    (state_r == sar_pkg::ST_ACK_DRV && scl_fall && is_ara_r && !start_c && !stop_c)
    |=> (state_r == sar_pkg::ST_TX_BYTE && tx_sr_r == sar_pkg::ALERT_REPLY))
    else $error("alert reply byte not loaded");

  a_arb_loss_abort: assert property (@(posedge clk) disable iff (!reset_n) // RQ3
    (state_r == sar_pkg::ST_TX_BYTE && is_ara_r && scl_rise && tx_sr_r[7] && !sda_s
     && !start_c && !stop_c) |=> (state_r == sar_pkg::ST_IGNORE && !sda_pin_oe))
    else $error("arbitration loss did not abort");

  a_alert_release: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    (ara_done && !hi_evt && !lo_evt) |=> !alert_or_charge_done_pin_oe)
    else $error("alert pin not released after reply");

  a_ack_slot_drive: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    (state_r == sar_pkg::ST_RX_CMD && scl_fall && bitcnt_r == sar_pkg::BITS_PER_BYTE
     && !start_c && !stop_c) |=> sda_pin_oe ##0 ptr_r == $past(rx_sr_r))
    else $error("command byte not acknowledged and latched");

  a_write_ptr_adv: assert property (@(posedge clk) disable iff (!reset_n) // RQ9
    (state_r == sar_pkg::ST_RX_DATA && scl_fall && bitcnt_r == sar_pkg::BITS_PER_BYTE
     && !start_c && !stop_c) |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("write pointer did not advance");

  a_read_ptr_adv: assert property (@(posedge clk) disable iff (!reset_n) // RQ10
    (state_r == sar_pkg::ST_TX_ACK && scl_fall && mack_r && !is_ara_r
     && !start_c && !stop_c) |=> (ptr_r == $past(ptr_r) + 8'h01 &&
     state_r == sar_pkg::ST_TX_BYTE))
    else $error("read pointer did not advance");

  a_flag_alert_set: assert property (@(posedge clk) disable iff (!reset_n) // RQ11
    (hi_evt && alert_mode && !wr_en) |=> (regs_r.flags[sar_pkg::FLAG_HIGH_BIT]
     && alert_or_charge_done_pin_oe))
    else $error("high threshold did not flag or alert");

  a_ara_no_pending: assert property (@(posedge clk) disable iff (!reset_n) // RQ12
    (state_r == sar_pkg::ST_RX_ADDR && scl_fall && bitcnt_r == sar_pkg::BITS_PER_BYTE
     && rx_sr_r == {sar_pkg::ALERT_RESP_ADDR, 1'b1} && !pending_r && !start_c && !stop_c)
    |=> (!sda_pin_oe)[*2])
    else $error("alert response acknowledged without pending alert");

  a_addr_ack_drive: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    (state_r == sar_pkg::ST_RX_ADDR && scl_fall && bitcnt_r == sar_pkg::BITS_PER_BYTE
     && rx_sr_r == {sar_pkg::DEV_ADDR, 1'b0} && !start_c && !stop_c) |=> sda_pin_oe)
    else $error("own write address not acknowledged");

  a_setup_write_lands: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    (wr_en && wr_addr == sar_pkg::REG_SETUP_CONTROL) |=> setup_value == $past(wr_data))
    else $error("control byte not stored");

  a_status_byte_load: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    (state_r == sar_pkg::ST_ACK_DRV && scl_fall && after_r == sar_pkg::ST_TX_BYTE && !is_ara_r
     && ptr_r == sar_pkg::REG_EVENT_FLAGS && !start_c && !stop_c)
    |=> tx_sr_r == $past(regs_r.flags))
    else $error("status byte not loaded for transmission");

  a_flag_low_set: assert property (@(posedge clk) disable iff (!reset_n) // RQ11
    (lo_evt && alert_mode && !wr_en) |=> (regs_r.flags[sar_pkg::FLAG_LOW_BIT]
     && alert_or_charge_done_pin_oe))
    else $error("low threshold did not flag or alert");

endmodule

/* testbench/sar_host_model.sv */
// serial bus master model, plus a second alerting slave that can pull data low
`timescale 1ns/10ps
module sar_host_model (
  output logic            scl,
  output logic            sda_low,
  output logic            rival_low,
  input  wire logic       sda,
  input  wire logic [7:0] clash,
  output logic            got_valid,
  output logic [8:0]      got_data
);
  // quarter of the 125 ns link period
  localparam real Q = 31.25;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rival_low = 1'b0;
    got_valid = 1'b0;
    got_data = 9'h000;
  end

  // data moves only while clock is low; sampled mid high phase
  task automatic bit9(input logic b, input logic r, output logic s);
    #Q;
    sda_low = ~b;
    rival_low = r;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda;
    #Q;
    scl = 1'b0;
  endtask

  // also serves as repeated start when clock is low
  task automatic start();
    #Q;
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
  endtask

  task automatic stop();
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b0;
  endtask

  // eight bits then the acknowledge slot; reports what the wire carried
  task automatic xfer(input logic [7:0] b, input logic last);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      bit9(b[i], clash[i], s);
      d[i] = s;
    end
    bit9(last, 1'b0, s);
    got_data = {s, d};
    got_valid = 1'b1;
    #1;
    got_valid = 1'b0;
  endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the alert response serial slave
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        reset_n;
  logic        step_up;
  logic        step_dn;
  logic        dev_o;
  logic        alert_o;
  logic [15:0] hi_thr;
  logic [15:0] lo_thr;
  logic [7:0]  clash;
  logic        scl;
  logic        host_low;
  logic        rival_low;
  logic        dev_oe;
  logic        alert_oe;
  logic        got_valid;
  logic [8:0]  got_data;
  logic [15:0] charge;
  logic [7:0]  setup;
  logic [7:0]  ctrl;
  logic [15:0] r;
  logic [31:0] rnd;
  logic [8:0]  exp_q[$];
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  wire         sda = (dev_oe ? dev_o : 1'b1) & ~host_low & ~rival_low;
  // alert line is open drain with a pull-up: low means an alert is pending
  wire         alert_n = alert_oe ? alert_o : 1'b1;

  sar_slave dut_u (
    .clk                         (clk),
    .reset_n                     (reset_n),
    .scl_pin                     (scl),
    .sda_pin_i                   (sda),
    .sda_pin_o                   (dev_o),
    .sda_pin_oe                  (dev_oe),
    .alert_or_charge_done_pin_o  (alert_o),
    .alert_or_charge_done_pin_oe (alert_oe),
    .charge_step_up              (step_up),
    .charge_step_down            (step_dn),
    .high_threshold              (hi_thr),
    .low_threshold               (lo_thr),
    .charge_count_value          (charge),
    .setup_value                 (setup)
  );

  sar_host_model host_u (
    .scl       (scl),
    .sda_low   (host_low),
    .rival_low (rival_low),
    .sda       (sda),
    .clash     (clash),
    .got_valid (got_valid),
    .got_data  (got_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic last, input logic [8:0] exp);
    exp_q.push_back(exp);
    host_u.xfer(b, last);
  endtask

  // bytes go out from the top of d
  task automatic wr(input logic [7:0] cmd, input logic [23:0] d, input int n);
    host_u.start();
    send(8'hC8, 1'b1, 9'h0C8);
    send(cmd, 1'b1, {1'b0, cmd});
    for (int i = 0; i < n; i++) begin
      send(d[23:16], 1'b1, {1'b0, d[23:16]});
      d = d << 8;
    end
    host_u.stop();
  endtask

  // master acknowledges every byte but the last
  task automatic rd(input logic [7:0] cmd, input logic [15:0] e, input int n);
    host_u.start();
    send(8'hC8, 1'b1, 9'h0C8);
    send(cmd, 1'b1, {1'b0, cmd});
    host_u.start();
    send(8'hC9, 1'b1, 9'h0C9);
    for (int i = 0; i < n; i++) begin
      send(8'hFF, i == n - 1, {i == n - 1, e[15:8]});
      e = e << 8;
    end
    host_u.stop();
  endtask

  task automatic ara(input logic acked, input logic [7:0] b);
    host_u.start();
    send(8'h19, 1'b1, {~acked, 8'h19});
    if (acked)
      send(8'hFF, 1'b1, {1'b1, b});
    host_u.stop();
  endtask

  always @(posedge got_valid) begin
    check({7'h00, got_data}, {7'h00, exp_q.pop_front()});
  end

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    step_up = 1'b0;
    step_dn = 1'b0;
    hi_thr = 16'hFFFF;
    lo_thr = 16'h0000;
    clash = 8'h00;
    rnd = $urandom(49);
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 check(charge, 16'h7FFF);
    check({8'h00, setup}, 16'h003C);
    check({15'h0000, alert_n}, 16'h0001);
    ara(1'b0, 8'h00);
    rnd = $urandom;
    ctrl = (rnd[7:0] & 8'hF9) | 8'h04;
    wr(8'h01, {ctrl, 16'h0000}, 1);
    check({8'h00, setup}, {8'h00, ctrl});
    rnd = $urandom;
    r = {1'b1, rnd[14:1], 1'b0};
    // third byte lands past the charge pair and is dropped
    wr(8'h02, {r, 8'h5A}, 3);
    check(charge, r);
    @(posedge clk);
    #1 step_up = 1'b1;
    @(posedge clk);
    #1 step_up = 1'b0;
    rd(8'h02, r + 16'h0001, 2);
    rd(8'h03, {r[7:0] + 8'h01, 8'h00}, 2);
    rd(8'h00, 16'h0000, 1);
    @(posedge clk);
    #1 hi_thr = r;
    repeat (4) @(posedge clk);
    #1 check({15'h0000, alert_n}, 16'h0000);
    rd(8'h00, 16'h0800, 1);
    clash = 8'h80;
    ara(1'b1, 8'h7F);
    clash = 8'h00;
    check({15'h0000, alert_n}, 16'h0000);
    ara(1'b1, 8'hC9);
    check({15'h0000, alert_n}, 16'h0001);
    ara(1'b0, 8'h00);
    // step the charge back to r and lift the low threshold just above it
    @(posedge clk);
    #1 step_dn = 1'b1;
    lo_thr = r + 16'h0001;
    @(posedge clk);
    #1 step_dn = 1'b0;
    repeat (4) @(posedge clk);
    #1 check({15'h0000, alert_n}, 16'h0000);
    check(charge, r);
    // high flag still latched from before, low flag newly set
    rd(8'h00, 16'h0C00, 1);
    ara(1'b1, 8'hC9);
    check({15'h0000, alert_n}, 16'h0001);
    #100;
    finish_test();
  end
endmodule
